// File: rtl/gts_timer_set.sv
// three-timer set with apb registers, 32-bit pairing and capture time base
//
// Implementation choices: register access over APB and the register offsets.
`timescale 1ns/1ps
`default_nettype none
module gts_timer_set (
   // apb
   input  wire logic        pclk,
   input  wire logic        presetn,
   input  wire logic        psel,
   input  wire logic        penable,
   input  wire logic        pwrite,
   input  wire logic [11:0] paddr,
   input  wire logic [31:0] pwdata,
   input  wire logic [3:0]  pstrb,
   output logic      [31:0] prdata,
   output logic             pready,
   output logic             pslverr,
   // device power state
   input  wire logic        idle_mode,
   // pins
   input  wire logic        first_ext_clock_pin,
   input  wire logic        second_ext_clock_pin,
   input  wire logic        third_ext_clock_pin,
   // event flags and triggers
   output logic             first_irq_flag,
   output logic             second_irq_flag,
   output logic             third_irq_flag,
   output logic             adc_trigger,
   // capture and compare time base
   output logic      [15:0] second_time_base,
   output logic      [15:0] third_time_base
);
   typedef struct packed {
      logic [15:0] c1;
      logic [15:0] c2;
      logic [15:0] c3;
      logic [15:0] cnt1;
      logic [15:0] cnt2;
      logic [15:0] cnt3;
      logic [15:0] per1;
      logic [15:0] per2;
      logic [15:0] per3;
      logic        f1;
      logic        f2;
      logic        f3;
      logic        adc;
      logic [31:0] rdata;
      logic        ready;
      logic        err;
      logic [15:0] tb2;
      logic [15:0] tb3;
   } gts_top_s;
   gts_top_s s_q, s_d;
   gts_tick_if t1 ();
   gts_tick_if t2 ();
   gts_tick_if t3 ();
   logic        wide;
   logic        acc;
   logic        wr;
   logic [15:0] wd;
   logic [31:0] wcnt;
   logic [31:0] wper;
   logic [31:0] wnext;
   logic        wmatch;
   logic        m1;
   logic        m2;
   logic        m3;
   logic        set1;
   logic        set2;
   logic        set3;
   // gate inputs share the external clock pins
   assign wide         = s_q.c2[gts_pkg::wide_pos];
   assign t1.ctrl      = s_q.c1;
   assign t1.ext_pin   = first_ext_clock_pin;
   assign t1.gate_pin  = first_ext_clock_pin;
   assign t1.halted    = idle_mode && s_q.c1[gts_pkg::idle_pos];
   assign t2.ctrl      = s_q.c2;
   assign t2.ext_pin   = second_ext_clock_pin;
   assign t2.gate_pin  = second_ext_clock_pin;
   assign t2.halted    = idle_mode && s_q.c2[gts_pkg::idle_pos];
   // wide mode: third timer's own control bits take no part
   assign t3.ctrl      = wide ? gts_pkg::ctrl_reset : s_q.c3;
   assign t3.ext_pin   = third_ext_clock_pin;
   assign t3.gate_pin  = third_ext_clock_pin;
   assign t3.halted    = idle_mode && s_q.c3[gts_pkg::idle_pos];
   gts_ticker #(.allow_async(1'b1)) u_tk1 (
      .pclk    (pclk),
      .presetn (presetn),
      .tif     (t1.tk)
   );
   gts_ticker #(.allow_async(1'b0)) u_tk2 (
      .pclk    (pclk),
      .presetn (presetn),
      .tif     (t2.tk)
   );
   gts_ticker #(.allow_async(1'b0)) u_tk3 (
      .pclk    (pclk),
      .presetn (presetn),
      .tif     (t3.tk)
   );
   always_comb begin
      acc    = psel && penable;
      wr     = acc && pwrite;
      wd     = pwdata[15:0];
      wcnt   = {s_q.cnt3, s_q.cnt2};
      wper   = {s_q.per3, s_q.per2};
      wnext  = wcnt + 32'h0000_0001;
      wmatch = wcnt == wper;
      m1     = s_q.cnt1 == s_q.per1;
      m2     = s_q.cnt2 == s_q.per2;
      m3     = s_q.cnt3 == s_q.per3;
      // flag set events of this cycle, so a clear never masks them
      set1   = t1.gate_fall || (t1.tick && m1);
      set2   = !wide && (t2.gate_fall || (t2.tick && m2));
      set3   = wide ? (t2.gate_fall || (t2.tick && wmatch))
                    : (t3.gate_fall || (t3.tick && m3));
      s_d    = s_q;
      s_d.ready = acc && !s_q.ready;
      s_d.err   = 1'b0;
      s_d.adc   = 1'b0;
      // first timer
      if (t1.tick) begin
         s_d.cnt1 = m1 ? 16'h0000 : s_q.cnt1 + 16'h0001;
         if (m1) begin
            s_d.f1 = 1'b1;
         end
      end
      if (t1.gate_fall) begin
         s_d.f1 = 1'b1;
      end
      // second and third timers, joined or apart
      if (wide) begin
         if (t2.tick) begin
            s_d.cnt2 = wmatch ? 16'h0000 : wnext[15:0];
            s_d.cnt3 = wmatch ? 16'h0000 : wnext[31:16];
            if (wmatch) begin
               s_d.f3  = 1'b1;
               s_d.adc = 1'b1;
            end
         end
         if (t2.gate_fall) begin
            s_d.f3 = 1'b1;
         end
      end else begin
         if (t2.tick) begin
            s_d.cnt2 = m2 ? 16'h0000 : s_q.cnt2 + 16'h0001;
            if (m2) begin
               s_d.f2 = 1'b1;
            end
         end
         if (t2.gate_fall) begin
            s_d.f2 = 1'b1;
         end
         if (t3.tick) begin
            s_d.cnt3 = m3 ? 16'h0000 : s_q.cnt3 + 16'h0001;
            if (m3) begin
               s_d.f3 = 1'b1;
            end
         end
         if (t3.gate_fall) begin
            s_d.f3 = 1'b1;
         end
      end
      // register writes; a flag set in the same cycle wins over its clear
      if (wr && !s_q.ready && pstrb[1:0] == 2'b11) begin
         unique case (paddr)
            gts_pkg::first_ctrl_off: begin
               s_d.c1 = wd & gts_pkg::first_ctrl_mask;
            end
            gts_pkg::second_ctrl_off: begin
               s_d.c2 = wd & gts_pkg::second_ctrl_mask;
            end
            gts_pkg::third_ctrl_off: begin
               s_d.c3 = wd & gts_pkg::third_ctrl_mask;
            end
            gts_pkg::first_count_off: begin
               s_d.cnt1 = wd;
            end
            gts_pkg::second_count_off: begin
               s_d.cnt2 = wd;
            end
            gts_pkg::third_count_off: begin
               s_d.cnt3 = wd;
            end
            gts_pkg::first_period_off: begin
               s_d.per1 = wd;
            end
            gts_pkg::second_period_off: begin
               s_d.per2 = wd;
            end
            gts_pkg::third_period_off: begin
               s_d.per3 = wd;
            end
            gts_pkg::status_off: begin
               if (wd[0] && !set1) begin
                  s_d.f1 = 1'b0;
               end
               if (wd[1] && !set2) begin
                  s_d.f2 = 1'b0;
               end
               if (wd[2] && !set3) begin
                  s_d.f3 = 1'b0;
               end
            end
            default: begin
               s_d.err = 1'b1;
            end
         endcase
      end else if (wr && !s_q.ready) begin
         s_d.err = !(paddr <= gts_pkg::mode_off && paddr[1:0] == 2'b00);
      end
      // reads
      if (acc && !pwrite && !s_q.ready) begin
         s_d.rdata = 32'h0000_0000;
         unique case (paddr)
            gts_pkg::first_ctrl_off:    s_d.rdata[15:0] = s_q.c1;
            gts_pkg::second_ctrl_off:   s_d.rdata[15:0] = s_q.c2;
            gts_pkg::third_ctrl_off:    s_d.rdata[15:0] = s_q.c3;
            gts_pkg::first_count_off:   s_d.rdata[15:0] = s_q.cnt1;
            gts_pkg::second_count_off:  s_d.rdata[15:0] = s_q.cnt2;
            gts_pkg::third_count_off:   s_d.rdata[15:0] = s_q.cnt3;
            gts_pkg::first_period_off:  s_d.rdata[15:0] = s_q.per1;
            gts_pkg::second_period_off: s_d.rdata[15:0] = s_q.per2;
            gts_pkg::third_period_off:  s_d.rdata[15:0] = s_q.per3;
            gts_pkg::status_off: begin
               s_d.rdata[2:0] = {s_q.f3, s_q.f2, s_q.f1};
            end
            gts_pkg::mode_off:          s_d.rdata[0] = wide;
            default:                    s_d.err = 1'b1;
         endcase
      end
      s_d.tb2 = s_d.cnt2;
      s_d.tb3 = s_d.cnt3;
   end
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         s_q       <= '0;
         s_q.per1  <= gts_pkg::period_reset;
         s_q.per2  <= gts_pkg::period_reset;
         s_q.per3  <= gts_pkg::period_reset;
      end else begin
         s_q <= s_d;
      end
   end
   assign prdata           = s_q.rdata;
   assign pready           = s_q.ready;
   assign pslverr          = s_q.err;
   assign first_irq_flag   = s_q.f1;
   assign second_irq_flag  = s_q.f2;
   assign third_irq_flag   = s_q.f3;
   assign adc_trigger      = s_q.adc;
   assign second_time_base = s_q.tb2;
   assign third_time_base  = s_q.tb3;
endmodule : gts_timer_set
`default_nettype wire

// File: rtl/gts_pkg.sv
// package of register map, field positions and constants for the timer set
package gts_pkg;
   localparam logic [11:0] first_ctrl_off   = 12'h000;
   localparam logic [11:0] first_count_off  = 12'h004;
   localparam logic [11:0] first_period_off = 12'h008;
   localparam logic [11:0] second_ctrl_off  = 12'h00c;
   localparam logic [11:0] second_count_off = 12'h010;
   localparam logic [11:0] second_period_off= 12'h014;
   localparam logic [11:0] third_ctrl_off   = 12'h018;
   localparam logic [11:0] third_count_off  = 12'h01c;
   localparam logic [11:0] third_period_off = 12'h020;
   localparam logic [11:0] status_off       = 12'h024;
   localparam logic [11:0] mode_off         = 12'h028;
   localparam int run_pos      = 15;
   localparam int idle_pos     = 13;
   localparam int gate_pos     = 6;
   localparam int pre_hi_pos   = 5;
   localparam int pre_lo_pos   = 4;
   localparam int wide_pos     = 3;
   localparam int sync_pos     = 2;
   localparam int src_pos      = 1;
   // writable bits per control register, others read as zero
   localparam logic [15:0] first_ctrl_mask  = 16'ha076;
   localparam logic [15:0] second_ctrl_mask = 16'ha07a;
   localparam logic [15:0] third_ctrl_mask  = 16'ha072;
   localparam logic [15:0] ctrl_reset       = 16'h0000;
   localparam logic [15:0] period_reset     = 16'hffff;
   localparam logic [7:0]  pre_div8         = 8'h07;
   localparam logic [7:0]  pre_div64        = 8'h3f;
   localparam logic [7:0]  pre_div256       = 8'hff;
endpackage : gts_pkg

// File: rtl/gts_tick_if.sv
// interface carrying control and count events into one timer channel
`timescale 1ns/1ps
`default_nettype none
interface gts_tick_if;
   logic [15:0] ctrl;
   logic        ext_pin;
   logic        gate_pin;
   logic        halted;
   logic        tick;
   logic        gate_fall;
   modport ctl (output ctrl, output ext_pin, output gate_pin, output halted,
                input tick, input gate_fall);
   modport tk  (input ctrl, input ext_pin, input gate_pin, input halted,
                output tick, output gate_fall);
endinterface : gts_tick_if
`default_nettype wire

// File: rtl/gts_ticker.sv
// per-timer clock selection, edge detect, gating and prescaler
`timescale 1ns/1ps
`default_nettype none
module gts_ticker #(
   parameter bit allow_async = 1'b0
) (
   // clock and reset
   input  wire logic pclk,
   input  wire logic presetn,
   // control and events
   gts_tick_if.tk    tif
);
   typedef struct packed {
      logic       sync1;
      logic       sync2;
      logic       ext_last;
      logic       gate_last;
      logic [7:0] pre_cnt;
      logic       tick;
      logic       gate_fall;
   } gts_tk_s;
   gts_tk_s s_q, s_d;
   logic       ext_src;
   logic       use_sync;
   logic       gated;
   logic       ext_now;
   logic       raw_in;
   logic [7:0] div_max;
   always_comb begin
      ext_src  = tif.ctrl[gts_pkg::src_pos];
      // unsynchronised counting only on the first timer
      use_sync = !allow_async || tif.ctrl[gts_pkg::sync_pos];
      gated    = !ext_src && tif.ctrl[gts_pkg::gate_pos];
      ext_now  = use_sync ? s_q.sync2 : tif.ext_pin;
      unique case (tif.ctrl[gts_pkg::pre_hi_pos:gts_pkg::pre_lo_pos])
         2'b00: div_max = 8'h00;
         2'b01: div_max = gts_pkg::pre_div8;
         2'b10: div_max = gts_pkg::pre_div64;
         2'b11: div_max = gts_pkg::pre_div256;
      endcase
      if (ext_src) begin
         raw_in = ext_now && !s_q.ext_last;
      end else begin
         raw_in = !gated || tif.gate_pin;
      end
      s_d           = s_q;
      s_d.sync1     = tif.ext_pin;
      s_d.sync2     = s_q.sync1;
      s_d.ext_last  = ext_now;
      s_d.gate_last = tif.gate_pin;
      s_d.tick      = 1'b0;
      s_d.gate_fall = gated && s_q.gate_last && !tif.gate_pin
                      && tif.ctrl[gts_pkg::run_pos];
      if (!tif.ctrl[gts_pkg::run_pos] || tif.halted) begin
         s_d.pre_cnt = 8'h00;
      end else if (raw_in) begin
         if (s_q.pre_cnt >= div_max) begin
            s_d.pre_cnt = 8'h00;
            s_d.tick    = 1'b1;
         end else begin
            s_d.pre_cnt = s_q.pre_cnt + 8'h01;
         end
      end
   end
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         s_q <= '0;
      end else begin
         s_q <= s_d;
      end
   end
   assign tif.tick      = s_q.tick;
   assign tif.gate_fall = s_q.gate_fall;
endmodule : gts_ticker
`default_nettype wire

// File: bench/gts_pin_model.sv
// external clock and gate pin model for one timer
`timescale 1ns/1ps
`default_nettype none
module gts_pin_model (
   // clock
   input  wire logic       pclk,
   // control
   input  wire logic       en,
   input  wire logic       lvl,
   input  wire logic [3:0] half,
   // pin
   output logic            pin
);
   logic [3:0] cnt_q;
   logic       tog_q;
   // toggles only while enabled, otherwise stands at the level given
   always_ff @(posedge pclk) begin
      if (!en) begin
         cnt_q <= 4'h0;
         tog_q <= 1'b0;
      end else if (cnt_q == half - 4'h1) begin
         cnt_q <= 4'h0;
         tog_q <= ~tog_q;
      end else begin
         cnt_q <= cnt_q + 4'h1;
      end
   end
   assign pin = en ? tog_q : lvl;
endmodule // gts_pin_model
`default_nettype wire

// File: bench/gts_timer_set_props.sv
// port checker for the timer set
`timescale 1ns/1ps
`default_nettype none
module gts_props (
   // apb
   input wire logic        pclk,
   input wire logic        presetn,
   input wire logic        psel,
   input wire logic        penable,
   input wire logic        pwrite,
   input wire logic [31:0] prdata,
   input wire logic        pready,
   input wire logic        pslverr,
   // events and time base
   input wire logic        first_irq_flag,
   input wire logic        third_irq_flag,
   input wire logic        adc_trigger,
   input wire logic [15:0] second_time_base,
   input wire logic [15:0] third_time_base
);
   default clocking cb @(posedge pclk); endclocking
   default disable iff (!presetn);
   AST_RDY: assert property (psel && penable && !pready |=> pready)
      else $error("access not answered");
   AST_ONE: assert property (pready |=> !pready)
      else $error("ready longer than one cycle");
   AST_HI: assert property (pready |-> prdata[31:16] == 16'h0000)
      else $error("upper read bits not zero");
   AST_ERR: assert property (pslverr |-> pready)
      else $error("error without ready");
   AST_ADC: assert property (adc_trigger |=> !adc_trigger)
      else $error("trigger longer than one cycle");
   AST_ADCF: assert property (adc_trigger |-> ##[0:2] third_irq_flag)
      else $error("wide match without third flag");
   AST_STK: assert property (first_irq_flag &&
      !(psel && pwrite) |=> first_irq_flag)
      else $error("first flag dropped");
   AST_STEP2: assert property (!$stable(second_time_base) &&
      !$past(psel) && !$past(psel, 2) && !$past(psel, 3) |->
      second_time_base == $past(second_time_base) + 16'h0001
      || second_time_base == 16'h0000)
      else $error("second count jumped");
   AST_STEP3: assert property (!$stable(third_time_base) &&
      !$past(psel) && !$past(psel, 2) && !$past(psel, 3) |->
      third_time_base == $past(third_time_base) + 16'h0001
      || third_time_base == 16'h0000)
      else $error("third count jumped");
endmodule // gts_props
bind gts_timer_set gts_props u_props (
   .pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable),
   .pwrite(pwrite), .prdata(prdata), .pready(pready), .pslverr(pslverr),
   .first_irq_flag(first_irq_flag), .third_irq_flag(third_irq_flag),
   .adc_trigger(adc_trigger), .second_time_base(second_time_base),
   .third_time_base(third_time_base));
`default_nettype wire

// File: bench/tb_general_timer_set_16_32bit.sv
// self-checking testbench of the timer set
`timescale 1ns/1ps
`default_nettype none
module tb_general_timer_set_16_32bit;
   logic        pclk = 1'b0, presetn = 1'b0, idle_mode = 1'b0;
   logic        psel = 1'b0, penable = 1'b0, pwrite = 1'b0;
   logic [11:0] paddr = 12'h000;
   logic [31:0] pwdata = 32'h0, prdata, r;
   logic        en1 = 1'b0, lv1 = 1'b0, en2 = 1'b0, lv2 = 1'b0;
   logic        pready, pslverr, pin1, pin2, f1, f2, f3, adc, e;
   logic [15:0] tb2, tb3;
   logic [3:0]  ev;
   int          fail_count = 0, num_checks = 0, adc_n = 0, g;
   assign ev = {adc, f3, f2, f1};
   always #2.5 pclk = ~pclk;
   always @(negedge pclk) if (adc === 1'b1) adc_n++;
   gts_pin_model m1 (.pclk(pclk), .en(en1), .lvl(lv1), .half(4'h2),
                     .pin(pin1));
   gts_pin_model m2 (.pclk(pclk), .en(en2), .lvl(lv2), .half(4'h4),
                     .pin(pin2));
   gts_timer_set uut (.pclk(pclk), .presetn(presetn), .psel(psel),
      .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata),
      .pstrb(4'hf), .prdata(prdata), .pready(pready), .pslverr(pslverr),
      .idle_mode(idle_mode), .first_ext_clock_pin(pin1),
      .second_ext_clock_pin(pin2), .third_ext_clock_pin(1'b0),
      .first_irq_flag(f1), .second_irq_flag(f2), .third_irq_flag(f3),
      .adc_trigger(adc), .second_time_base(tb2), .third_time_base(tb3));
   task automatic tally_and_finish;
      $display("checks %0d mismatches %0d", num_checks, fail_count);
      if (fail_count == 0 && num_checks > 0) $display("All checks passed");
      else $display("Checks failed");
      $finish;
   endtask
   task automatic chk(input logic [31:0] got, input logic [31:0] exp);
      num_checks++;
      if (got !== exp) begin
         $display("mismatch t=%0t got=%h exp=%h", $time, got, exp);
         fail_count++;
      end
   endtask
   // one apb transfer; result left in r and e
   task automatic apb(input logic w, input logic [11:0] a,
                      input logic [31:0] d);
      int n;
      @(posedge pclk);
      psel <= 1'b1;
      pwrite <= w;
      paddr <= a;
      pwdata <= d;
      @(posedge pclk);
      penable <= 1'b1;
      n = 0;
      // pready is looked at on the rising edge, where it is sampled
      @(posedge pclk);
      while (pready !== 1'b1 && n < 40) begin
         @(posedge pclk);
         n++;
      end
      if (n >= 40) begin fail_count++; tally_and_finish; end
      r = prdata;
      e = pslverr;
      psel <= 1'b0;
      penable <= 1'b0;
   endtask
   task automatic wr(input logic [11:0] a, input logic [31:0] d);
      apb(1'b1, a, d);
   endtask
   task automatic rd(input logic [11:0] a);
      apb(1'b0, a, 32'h0);
   endtask
   task automatic wait_ev(input int b);
      int n;
      n = 0;
      while (ev[b] !== 1'b1 && n < 300) begin @(negedge pclk); n++; end
      if (n >= 300) begin fail_count++; tally_and_finish; end
   endtask
   // cycles between two successive steps of the second time base
   task automatic gap;
      logic [15:0] v;
      int n;
      n = 0;
      @(negedge pclk);
      v = tb2;
      while (tb2 === v && n < 600) begin @(negedge pclk); n++; end
      v = tb2;
      g = 0;
      while (tb2 === v && g < 600) begin @(negedge pclk); g++; end
      if (g >= 600 || n >= 600) begin fail_count++; tally_and_finish; end
      @(posedge pclk);
   endtask
   task automatic still;
      logic [15:0] v;
      repeat (8) @(negedge pclk);
      v = tb2;
      repeat (20) @(negedge pclk);
      chk({16'h0, tb2}, {16'h0, v});
      @(posedge pclk);
   endtask
   task automatic t_regs;
      logic [11:0] oa [3];
      logic [15:0] ma [3];
      oa = '{gts_pkg::first_ctrl_off, gts_pkg::second_ctrl_off,
             gts_pkg::third_ctrl_off};
      ma = '{gts_pkg::first_ctrl_mask, gts_pkg::second_ctrl_mask,
             gts_pkg::third_ctrl_mask};
      rd(gts_pkg::first_period_off);
      chk(r, {16'h0, gts_pkg::period_reset});
      for (int i = 0; i < 3; i++) begin
         rd(oa[i]);
         chk(r, 32'h0);
         wr(oa[i], 32'hffff);
         rd(oa[i]);
         chk(r, {16'h0, ma[i]});
         wr(oa[i], 32'h0);
      end
      rd(12'h0fc);
      chk({31'h0, e}, 32'h1);
   endtask
   task automatic t_prescale;
      int dv [4];
      dv = '{1, 8, 64, 256};
      for (int k = 0; k < 4; k++) begin
         wr(gts_pkg::second_ctrl_off, 32'h8000 | (k << 4));
         gap;
         chk(32'(g), 32'(dv[k]));
      end
   endtask
   task automatic t_modes;
      wr(gts_pkg::second_ctrl_off, 32'h8042);
      en2 <= 1'b1;
      gap;
      chk(32'(g), 32'h8);
      en2 <= 1'b0;
      still;
      wr(gts_pkg::second_ctrl_off, 32'h8040);
      still;
      lv2 <= 1'b1;
      gap;
      chk(32'(g), 32'h1);
      idle_mode <= 1'b1;
      wr(gts_pkg::second_ctrl_off, 32'ha000);
      still;
      wr(gts_pkg::second_ctrl_off, 32'h8000);
      gap;
      chk(32'(g), 32'h1);
      idle_mode <= 1'b0;
   endtask
   task automatic t_first;
      wr(gts_pkg::first_period_off, 32'h3);
      wr(gts_pkg::first_ctrl_off, 32'h8002);
      en1 <= 1'b1;
      wait_ev(0);
      wr(gts_pkg::first_ctrl_off, 32'h0);
      wr(gts_pkg::status_off, 32'h7);
      repeat (30) @(negedge pclk);
      chk({31'h0, f1}, 32'h0);
      wr(gts_pkg::first_ctrl_off, 32'h8006);
      wait_ev(0);
      wr(gts_pkg::first_ctrl_off, 32'h0);
      lv1 <= 1'b1;
      en1 <= 1'b0;
      wr(gts_pkg::status_off, 32'h7);
      wr(gts_pkg::first_period_off, 32'hffff);
      wr(gts_pkg::first_ctrl_off, 32'h8040);
      lv1 <= 1'b0;
      wait_ev(0);
      wr(gts_pkg::first_ctrl_off, 32'h0);
   endtask
   task automatic t_wide;
      int n0;
      wr(gts_pkg::second_ctrl_off, 32'h8);
      wr(gts_pkg::second_period_off, 32'hffff);
      wr(gts_pkg::third_period_off, 32'hffff);
      wr(gts_pkg::second_count_off, 32'hffff);
      wr(gts_pkg::third_count_off, 32'h0);
      wr(gts_pkg::second_ctrl_off, 32'h8008);
      repeat (4) @(posedge pclk);
      wr(gts_pkg::second_ctrl_off, 32'h8);
      rd(gts_pkg::third_count_off);
      chk(r, 32'h1);
      chk({16'h0, tb3}, 32'h1);
      wr(gts_pkg::second_period_off, 32'h4);
      wr(gts_pkg::third_period_off, 32'h0);
      wr(gts_pkg::second_count_off, 32'h0);
      wr(gts_pkg::third_count_off, 32'h0);
      wr(gts_pkg::status_off, 32'h7);
      wr(gts_pkg::second_ctrl_off, 32'h8008);
      wait_ev(3);
      chk({30'h0, f3, f2}, 32'h2);
      wr(gts_pkg::second_ctrl_off, 32'h0);
      n0 = adc_n;
      wr(gts_pkg::second_period_off, 32'h2);
      // the count left by the wide run lies above the new period
      wr(gts_pkg::second_count_off, 32'h0);
      wr(gts_pkg::status_off, 32'h7);
      wr(gts_pkg::second_ctrl_off, 32'h8000);
      wait_ev(1);
      chk(32'(adc_n), 32'(n0));
      // third timer on its own
      wr(gts_pkg::third_period_off, 32'h2);
      wr(gts_pkg::third_count_off, 32'h0);
      wr(gts_pkg::third_ctrl_off, 32'h8000);
      wait_ev(2);
   endtask
   // mid-run reset while timers run and flags stand
   task automatic t_reset;
      @(posedge pclk);
      presetn <= 1'b0;
      repeat (2) @(posedge pclk);
      presetn <= 1'b1;
      chk({16'h0, tb2}, 32'h0);
      rd(gts_pkg::status_off);
      chk(r, 32'h0);
      rd(gts_pkg::second_ctrl_off);
      chk(r, 32'h0);
      rd(gts_pkg::third_period_off);
      chk(r, {16'h0, gts_pkg::period_reset});
   endtask
   initial begin
      repeat (3) @(posedge pclk);
      presetn <= 1'b1;
      t_regs;
      t_prescale;
      t_modes;
      t_first;
      t_wide;
      t_reset;
      tally_and_finish;
   end
endmodule // tb_general_timer_set_16_32bit
`default_nettype wire
